//--- rtl/dsm_pkg.sv
package dsm_pkg;
    // register byte offsets on the bus
    localparam logic [7:0] DSM_CTRL_OFS = 8'h00;
    localparam logic [7:0] DSM_SRC_OFS = 8'h04;
    localparam logic [7:0] DSM_CAR_OFS = 8'h08;
    localparam logic [7:0] DSM_STAT_OFS = 8'h0C;
    localparam int DSM_ADDR_W = 8;
    localparam int DSM_REG_W = 16;
    localparam int DSM_SEL_W = 4;
    localparam int DSM_NSRC = 16;
    // control register fields
    localparam int DSM_CTRL_IDLE_STOP = 14;
    localparam int DSM_CTRL_MANUAL = 0;
    // source register fields
    localparam int DSM_SRC_ODIS = 7;
    localparam int DSM_SRC_SEL_LO = 0;
    // carrier register fields
    localparam int DSM_CAR_HI_ODIS = 15;
    localparam int DSM_CAR_HI_INV = 14;
    localparam int DSM_CAR_HI_SYNC = 13;
    localparam int DSM_CAR_HI_SEL_LO = 8;
    localparam int DSM_CAR_LO_ODIS = 7;
    localparam int DSM_CAR_LO_INV = 6;
    localparam int DSM_CAR_LO_SYNC = 5;
    localparam int DSM_CAR_LO_SEL_LO = 0;
    // status register fields
    localparam int DSM_STAT_OUT = 0;
    localparam int DSM_STAT_ON_HIGH = 1;
    localparam int DSM_STAT_DATA = 2;
    localparam int DSM_STAT_SRC_VALID = 3;
    // writable bit masks; all other bits read zero
    localparam logic [15:0] DSM_CTRL_MASK = 16'h4001;
    localparam logic [15:0] DSM_SRC_MASK = 16'h008F;
    localparam logic [15:0] DSM_CAR_MASK = 16'hEFEF;
    localparam logic [15:0] DSM_CAR_RST = 16'h0000;
    // data source encodings
    localparam logic [3:0] DSM_DSRC_MANUAL = 4'h0;
    localparam logic [3:0] DSM_DSRC_PIN = 4'h1;
    localparam logic [3:0] DSM_DSRC_SER1 = 4'h2;
    localparam logic [3:0] DSM_DSRC_UART1 = 4'h4;
    localparam logic [3:0] DSM_DSRC_OC1 = 4'h8;
    localparam logic [3:0] DSM_DSRC_NONE = 4'hF;
    // carrier source encodings
    localparam logic [3:0] DSM_CSRC_GND = 4'h0;
    localparam logic [3:0] DSM_CSRC_PIN1 = 4'h1;
    localparam logic [3:0] DSM_CSRC_PIN2 = 4'h2;
    localparam logic [3:0] DSM_CSRC_REF = 4'h3;
    localparam logic [3:0] DSM_CSRC_OC1 = 4'h4;
    localparam logic [3:0] DSM_CSRC_OC7 = 4'hA;

    // one-hot mask of a selector, empty when disabled
    function automatic logic [15:0] dsm_onehot(input logic [3:0] sel,
                                               input logic en);
        dsm_onehot = en ? (16'h0001 << sel) : 16'h0000;
    endfunction : dsm_onehot
endpackage : dsm_pkg

//--- rtl/dsm_carrier_path.sv
`timescale 1ns/10ps
`default_nettype none
module dsm_carrier_path
    import dsm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_run,
    input wire logic [3:0] i_sel,
    input wire logic i_invert,
    input wire logic [15:0] i_cands,
    output logic o_carrier,
    output logic o_fall
);
    logic raw;
    logic prev_r;

    // reserved encodings carry zeros in the candidate vector
    assign raw = i_cands[i_sel];
    assign o_carrier = raw ^ i_invert;
    // edge seen on the conditioned carrier, after inversion
    assign o_fall = prev_r & ~o_carrier;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            prev_r <= 1'b0;
        end else if (i_run) begin
            prev_r <= o_carrier;
        end
    end
endmodule : dsm_carrier_path
`default_nettype wire

//--- rtl/dsm_modulator.sv
`timescale 1ns/10ps
`default_nettype none
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// RL1: source output-disable bit disables the selected data source pin output.
// RL2: data selector picks manual bit, pin, serial, uart or compare output.
// RL3: source output-disable bit changes only at power-on reset; the code also loads it on every source register write.
// RL4: data selector bits are untouched by power-on reset.
// RL5: upper carrier output-disable bit disables that carrier source's pin.
// RL6: upper carrier invert bit inverts the selected upper carrier.
// RL7: upper sync waits for upper carrier falling edge before going low.
// RL8: upper selector picks ground, two pins, reference clock or compares.
// RL9: lower carrier output-disable bit disables that carrier source's pin.
// RL10: lower carrier invert bit inverts the selected lower carrier.
// RL11: lower sync waits for lower carrier falling edge before going high.
// RL12: lower selector uses the same encoding as the upper selector.
// RL13: unimplemented register bits read zero and ignore writes.
// RL14: unsynchronised switching may narrow pulses; sync avoids spurs.
// RL15: manual source takes data from the manual modulation bit.
// RL16: idle-stop bit halts the modulator while the device idles.
// RL17: data high outputs upper carrier, low outputs lower carrier.
module dsm_modulator
    import dsm_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_ce,
    input wire logic i_idle,
    input wire logic i_modulation_input_pin,
    input wire logic i_carrier_input_pin_one,
    input wire logic i_carrier_input_pin_two,
    input wire logic i_reference_oscillator_output,
    input wire logic i_serial_out_one,
    input wire logic i_serial_out_two,
    input wire logic [3:0] i_uart_tx,
    input wire logic [6:0] i_compare_out,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic o_hreadyout,
    output logic o_hresp,
    output logic [31:0] o_hrdata,
    output logic o_mod_out,
    output logic [15:0] o_data_src_disable,
    output logic [15:0] o_carrier_src_disable
);
    //////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    logic [2:0] pin_meta_r;
    logic [2:0] pin_sync_r;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            pin_meta_r <= 3'h0;
            pin_sync_r <= 3'h0;
        end else if (i_ce) begin
            pin_meta_r <= {i_carrier_input_pin_two, i_carrier_input_pin_one,
                           i_modulation_input_pin};
            pin_sync_r <= pin_meta_r;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // bus slave
    logic [DSM_ADDR_W-1:0] dph_addr_r;
    logic dph_wr_r;
    logic hready_r;
    logic [31:0] hrdata_r;
    logic [15:0] ctrl_r;
    logic [15:0] ctrl_nxt;
    logic source_output_disable_r;
    logic source_output_disable_nxt;
    logic [3:0] dsel_r;
    logic [3:0] dsel_nxt;
    logic dsel_valid_r;
    logic [15:0] car_r;
    logic [15:0] car_nxt;
    logic [15:0] status;
    logic [15:0] src_view;
    logic [15:0] rd_value;
    wire addr_take = i_hsel & i_htrans[1] & i_hready;
    wire wr_ctrl = dph_wr_r & (dph_addr_r == DSM_CTRL_OFS);
    wire wr_src = dph_wr_r & (dph_addr_r == DSM_SRC_OFS);
    wire wr_car = dph_wr_r & (dph_addr_r == DSM_CAR_OFS);
    wire [DSM_ADDR_W-1:0] rd_addr = i_haddr[DSM_ADDR_W-1:0];
    wire [15:0] wdat = i_hwdata[15:0];

    // writes land at the end of the data phase; masked bits stay zero
    assign ctrl_nxt = wr_ctrl ? (wdat & DSM_CTRL_MASK) : ctrl_r; // RL13
    assign source_output_disable_nxt = wr_src ? wdat[DSM_SRC_ODIS] : source_output_disable_r;
    assign dsel_nxt = wr_src ? wdat[DSM_SRC_SEL_LO +: DSM_SEL_W] : dsel_r;
    assign car_nxt = wr_car ? (wdat & DSM_CAR_MASK) : car_r; // RL13
    assign src_view = (16'h0001 << DSM_SRC_ODIS) & {16{source_output_disable_nxt}}
                      | {12'h000, dsel_nxt}; // RL13
    // reads use next values so a read right after a write sees it
    assign rd_value = (rd_addr == DSM_CTRL_OFS) ? ctrl_nxt :
                      (rd_addr == DSM_SRC_OFS) ? src_view :
                      (rd_addr == DSM_CAR_OFS) ? car_nxt :
                      (rd_addr == DSM_STAT_OFS) ? status : 16'h0000;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            dph_addr_r <= 8'h00;
            dph_wr_r <= 1'b0;
            hready_r <= 1'b1;
            hrdata_r <= 32'h00000000;
            ctrl_r <= 16'h0000;
            car_r <= DSM_CAR_RST;
        end else begin
            dph_addr_r <= i_haddr[DSM_ADDR_W-1:0];
            dph_wr_r <= addr_take & i_hwrite;
            hready_r <= 1'b1;
            if (addr_take & ~i_hwrite) begin
                hrdata_r <= {16'h0000, rd_value};
            end
            ctrl_r <= ctrl_nxt;
            car_r <= car_nxt;
        end
    end

    // the reset input doubles as power-on reset for this block
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            source_output_disable_r <= 1'b0; // RL3
        end else begin
            source_output_disable_r <= source_output_disable_nxt;
        end
    end

    // selector survives reset; its output is held off until first written
    always_ff @(posedge i_core_clk) begin
        dsel_r <= i_srst ? dsel_r : dsel_nxt; // RL4
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            dsel_valid_r <= 1'b0;
        end else if (wr_src) begin
            dsel_valid_r <= 1'b1;
        end
    end

    assign o_hreadyout = hready_r;
    assign o_hresp = 1'b0;
    assign o_hrdata = hrdata_r;

    //////////////////////////////////////////////////////////////////////////
    // source and carrier selection
    logic [15:0] data_cands;
    logic [15:0] car_cands;
    logic data_bit;
    logic run;
    logic hi_car;
    logic hi_fall;
    logic lo_car;
    logic lo_fall;
    wire idle_stop = ctrl_r[DSM_CTRL_IDLE_STOP];
    wire hi_sync = car_r[DSM_CAR_HI_SYNC];
    wire lo_sync = car_r[DSM_CAR_LO_SYNC];
    wire [3:0] hi_sel = car_r[DSM_CAR_HI_SEL_LO +: DSM_SEL_W];
    wire [3:0] lo_sel = car_r[DSM_CAR_LO_SEL_LO +: DSM_SEL_W];

    assign data_cands = {1'b0, i_compare_out, i_uart_tx, i_serial_out_two,
                         i_serial_out_one, pin_sync_r[0],
                         ctrl_r[DSM_CTRL_MANUAL]}; // RL2 RL15
    assign data_bit = dsel_valid_r & data_cands[dsel_r]; // RL2
    assign car_cands = {5'h00, i_compare_out, i_reference_oscillator_output,
                        pin_sync_r[2], pin_sync_r[1], 1'b0}; // RL8
    // idle-stop freezes the carrier edge history, phase and modulation output register
    assign run = i_ce & ~(idle_stop & i_idle); // RL16

    dsm_carrier_path u_upper (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_run(run),
        .i_sel(hi_sel), // RL8
        .i_invert(car_r[DSM_CAR_HI_INV]), // RL6
        .i_cands(car_cands),
        .o_carrier(hi_car),
        .o_fall(hi_fall)
    );

    dsm_carrier_path u_lower (
        .i_core_clk(i_core_clk),
        .i_srst(i_srst),
        .i_run(run),
        .i_sel(lo_sel), // RL12
        .i_invert(car_r[DSM_CAR_LO_INV]), // RL10
        .i_cands(car_cands),
        .o_carrier(lo_car),
        .o_fall(lo_fall)
    );

    //////////////////////////////////////////////////////////////////////////
    // carrier switching; unsynchronised switches can chop pulses short
    typedef enum logic [0:0] {DSM_ON_LOW, DSM_ON_HIGH} dsm_phase_t;
    dsm_phase_t phase_r;
    dsm_phase_t phase_nxt;
    logic mod_out_r;
    logic mod_out_nxt;
    logic [15:0] dsd_r;
    logic [15:0] csd_r;

    always_comb begin
        phase_nxt = phase_r;
        case (phase_r)
            DSM_ON_HIGH: begin
                if (!data_bit && (!hi_sync || hi_fall)) begin // RL7 RL14
                    phase_nxt = DSM_ON_LOW;
                end
            end
            DSM_ON_LOW: begin
                if (data_bit && (!lo_sync || lo_fall)) begin // RL11 RL14
                    phase_nxt = DSM_ON_HIGH;
                end
            end
            default: begin
                phase_nxt = DSM_ON_LOW;
            end
        endcase
    end

    assign mod_out_nxt = (phase_nxt == DSM_ON_HIGH) ? hi_car : lo_car; // RL17

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            phase_r <= DSM_ON_LOW;
            mod_out_r <= 1'b0;
        end else if (run) begin
            phase_r <= phase_nxt;
            mod_out_r <= mod_out_nxt;
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            dsd_r <= 16'h0000;
            csd_r <= 16'h0000;
        end else begin
            dsd_r <= dsm_onehot(dsel_r, source_output_disable_r & dsel_valid_r); // RL1
            csd_r <= dsm_onehot(hi_sel, car_r[DSM_CAR_HI_ODIS]) // RL5
                   | dsm_onehot(lo_sel, car_r[DSM_CAR_LO_ODIS]); // RL9
        end
    end

    assign status = {12'h000, dsel_valid_r, data_bit,
                     phase_r == DSM_ON_HIGH, mod_out_r};
    assign o_mod_out = mod_out_r;
    assign o_data_src_disable = dsd_r;
    assign o_carrier_src_disable = csd_r;

    //////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    sequence hi_leave_s;
        phase_r == DSM_ON_HIGH && run && !data_bit;
    endsequence
    sequence lo_leave_s;
        phase_r == DSM_ON_LOW && run && data_bit;
    endsequence
    sequence hi_stay_s;
        phase_r == DSM_ON_HIGH && run && data_bit;
    endsequence
    sequence lo_stay_s;
        phase_r == DSM_ON_LOW && run && !data_bit;
    endsequence

    upper_sync_hold_a: assert property ( // RL7
        hi_leave_s and (hi_sync && !hi_fall) |=> phase_r == DSM_ON_HIGH)
        else $error("left upper carrier without falling edge");
    upper_free_switch_a: assert property ( // RL7
        hi_leave_s and !hi_sync |=> phase_r == DSM_ON_LOW)
        else $error("unsynced switch to lower carrier missed");
    lower_sync_hold_a: assert property ( // RL11
        lo_leave_s and (lo_sync && !lo_fall) |=> phase_r == DSM_ON_LOW)
        else $error("left lower carrier without falling edge");
    lower_free_switch_a: assert property ( // RL11
        lo_leave_s and !lo_sync |=> phase_r == DSM_ON_HIGH)
        else $error("unsynced switch to upper carrier missed");
    output_follow_a: assert property ( // RL17
        run |=> mod_out_r == (phase_r == DSM_ON_HIGH ? $past(hi_car)
                                                     : $past(lo_car)))
        else $error("output not the active carrier");
    idle_freeze_a: assert property ( // RL16
        i_ce && idle_stop && i_idle
        |=> $stable(mod_out_r) && $stable(phase_r))
        else $error("modulator ran while idle-stopped");
    ce_freeze_a: assert property (
        !i_ce |=> $stable(mod_out_r) && $stable(phase_r))
        else $error("modulator ran with clock enable low");
    data_disable_a: assert property ( // RL1
        source_output_disable_r && dsel_valid_r |=> dsd_r == (16'h0001 << $past(dsel_r)))
        else $error("data source pin not disabled");
    carrier_disable_a: assert property ( // RL5
        car_r[DSM_CAR_HI_ODIS] |=> csd_r[$past(hi_sel)])
        else $error("upper carrier pin not disabled");
    lower_disable_a: assert property ( // RL9
        !car_r[DSM_CAR_HI_ODIS] && !car_r[DSM_CAR_LO_ODIS]
        |=> csd_r == 16'h0000)
        else $error("carrier pin disabled while enabled");
    lower_set_a: assert property ( // RL9
        car_r[DSM_CAR_LO_ODIS] |=> csd_r[$past(lo_sel)])
        else $error("lower carrier pin not disabled");
    reserved_zero_a: assert property ( // RL13
        (car_r & ~DSM_CAR_MASK) == 16'h0000
        && (ctrl_r & ~DSM_CTRL_MASK) == 16'h0000)
        else $error("unimplemented bit holds a one");
    manual_data_a: assert property ( // RL15
        dsel_valid_r && dsel_r == DSM_DSRC_MANUAL
        |-> data_bit == ctrl_r[DSM_CTRL_MANUAL])
        else $error("manual bit not used as data");
    // must look through reset, so the default disable is overridden
    sel_keep_a: assert property ( // RL4
        disable iff (1'b0)
        i_srst && dsel_valid_r |=> $stable(dsel_r))
        else $error("selector changed by reset");
    data_gate_a: assert property ( // RL4
        !dsel_valid_r |=> dsd_r == 16'h0000)
        else $error("data pin disabled before selector written");
    source_output_disable_keep_a: assert property ( // RL3
        !wr_src |=> $stable(source_output_disable_r))
        else $error("source disable bit moved without a write");
    upper_keep_a: assert property ( // RL17
        hi_stay_s |=> phase_r == DSM_ON_HIGH)
        else $error("left upper carrier with data high");
    lower_keep_a: assert property ( // RL17
        lo_stay_s |=> phase_r == DSM_ON_LOW)
        else $error("left lower carrier with data low");
    car_write_a: assert property ( // RL13
        addr_take && i_hwrite && rd_addr == DSM_CAR_OFS
        |-> ##2 car_r == ($past(wdat) & DSM_CAR_MASK))
        else $error("carrier register write lost");
    src_write_a: assert property ( // RL13
        addr_take && i_hwrite && rd_addr == DSM_SRC_OFS
        |-> ##2 {8'h00, source_output_disable_r, 3'h0, dsel_r}
                == ($past(wdat) & DSM_SRC_MASK))
        else $error("source register write lost");
    src_read_a: assert property ( // RL13
        addr_take && !i_hwrite && rd_addr == DSM_SRC_OFS
        |=> (o_hrdata[15:0] & ~DSM_SRC_MASK) == 16'h0000
            && o_hrdata[31:16] == 16'h0000)
        else $error("unimplemented source bit read as one");
endmodule : dsm_modulator
`default_nettype wire

//--- test/dsm_periph_model.sv
`timescale 1ns/10ps
`default_nettype none
module dsm_periph_model #(
    parameter int REF_DIV = 3
) (
    input wire logic i_core_clk,
    input wire logic [16:0] i_level,
    input wire logic i_ref_run,
    output logic [16:0] o_line
);
    ////////////////////////////////////////////////////////////////////////
    // reference clock reaches the line only on request, otherwise a held level
    logic ref_r = 1'b0;
    logic [3:0] cnt_r = 4'h0;
    wire logic wrap = (cnt_r == 4'(REF_DIV - 1));
    always_ff @(posedge i_core_clk) begin
        cnt_r <= wrap ? 4'h0 : cnt_r + 4'h1;
        if (wrap) begin
            ref_r <= ~ref_r;
        end
    end
    assign o_line = {i_level[16:4], i_ref_run ? ref_r : i_level[3],
                     i_level[2:0]};
endmodule : dsm_periph_model
`default_nettype wire

//--- test/signal_modulator_source_carrier_test.sv
`timescale 1ns/10ps
`default_nettype none
module signal_modulator_source_carrier_test;
    import dsm_pkg::*;
    typedef struct packed {
        logic [15:0] car;
        logic man;
        logic [16:0] lv;
        logic out;
        logic [15:0] cdis;
    } dsm_row_t;
    localparam dsm_row_t ROWS [8] = '{
        '{16'h0300, 1'b1, 17'h00008, 1'b1, 16'h0000},
        '{16'h4300, 1'b1, 17'h00008, 1'b0, 16'h0000},
        '{16'h8A00, 1'b1, 17'h10000, 1'b1, 16'h0400},
        '{16'h0B00, 1'b1, 17'h1FFFF, 1'b0, 16'h0000},
        '{16'h0082, 1'b0, 17'h00004, 1'b1, 16'h0004},
        '{16'h0040, 1'b0, 17'h00000, 1'b1, 16'h0000},
        '{16'h8384, 1'b0, 17'h00400, 1'b1, 16'h0018},
        '{16'h0000, 1'b1, 17'h1FFFF, 1'b0, 16'h0000}};
    // address, expected read-back after writing all ones
    localparam logic [23:0] RMAP [4] = '{24'h04008F, 24'h08EFEF,
                                         24'h004001, 24'h100000};
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic idle = 1'b0;
    logic ref_run = 1'b0;
    logic [16:0] lv = 17'h0;
    logic [16:0] line;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic hready;
    logic hresp;
    logic mod_out;
    logic [15:0] dsdis;
    logic [15:0] csdis;
    int n_fail = 0;
    int compares = 0;
    int cyc = 0;
    int moves;

    always #20 core_clk = ~core_clk;

    dsm_periph_model #(.REF_DIV(3)) dsm_periph_model_i (
        .i_core_clk(core_clk), .i_level(lv), .i_ref_run(ref_run),
        .o_line(line));
    dsm_modulator dsm_modulator_i (
        .i_core_clk(core_clk), .i_srst(srst), .i_ce(ce), .i_idle(idle),
        .i_modulation_input_pin(line[0]),
        .i_carrier_input_pin_one(line[1]),
        .i_carrier_input_pin_two(line[2]),
        .i_reference_oscillator_output(line[3]),
        .i_serial_out_one(line[4]), .i_serial_out_two(line[5]),
        .i_uart_tx(line[9:6]), .i_compare_out(line[16:10]),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hreadyout(hready), .o_hresp(hresp),
        .o_hrdata(hrdata), .o_mod_out(mod_out),
        .o_data_src_disable(dsdis), .o_carrier_src_disable(csdis));

    //////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("n_fail %0d compares %0d", n_fail, compares);
        if (n_fail == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] got, input logic [31:0] exp,
                         input string what);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : check

    // one single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [15:0] d);
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'h2;
        hsel <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= {16'h0, d};
        do begin
            @(posedge core_clk);
        end while (hready !== 1'b1);
        q = hrdata;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask : wr

    // pins carry two sync stages, so allow a generous settle
    task automatic settle();
        repeat (8) @(posedge core_clk);
    endtask : settle

    task automatic count_moves(output int n);
        logic last;
        n = 0;
        last = mod_out;
        repeat (24) begin
            @(posedge core_clk);
            if (mod_out !== last) n++;
            last = mod_out;
        end
    endtask : count_moves

    task automatic sync_run(input logic [15:0] car, input logic d,
                            input logic held);
        wr(DSM_CAR_OFS, car);
        lv <= 17'h8;
        wr(DSM_CTRL_OFS, {15'h0, d});
        settle();
        wr(DSM_CTRL_OFS, {15'h0, ~d});
        settle();
        check(mod_out, held, "switch hold");
        bus(1'b0, DSM_STAT_OFS, 16'h0);
        check(q, {28'h0, 1'b1, ~d, ~(d ^ held), held}, "status hold");
        lv <= 17'h0;
        settle();
        check(mod_out, 1'b0, "after fall");
        lv <= 17'h8;
        settle();
        check(mod_out, 1'b0, "after rise");
    endtask : sync_run

    function automatic int dbit(input int k);
        return (k == 1) ? 0 : k + 2;
    endfunction : dbit

    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            complete_run();
        end
    end

    //////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge core_clk);
        check(32'(mod_out), 32'h0, "reset output");
        check({dsdis, csdis}, 32'h0, "reset disables");
        check({30'h0, hready, hresp}, 32'h2, "reset bus answer");
        srst <= 1'b0;
        bus(1'b0, DSM_CTRL_OFS, 16'h0);
        check(q, 32'h0, "control reset");
        bus(1'b0, DSM_CAR_OFS, 16'h0);
        check(q, DSM_CAR_RST, "carrier reset");
        foreach (RMAP[i]) begin
            wr(RMAP[i][23:16], 16'hFFFF);
            bus(1'b0, RMAP[i][23:16], 16'h0);
            check(q, RMAP[i][15:0], "reserved bits");
        end
        wr(DSM_SRC_OFS, 16'h0000);
        foreach (ROWS[i]) begin
            wr(DSM_CAR_OFS, ROWS[i].car);
            wr(DSM_CTRL_OFS, {15'h0, ROWS[i].man});
            lv <= ROWS[i].lv;
            settle();
            check(mod_out, ROWS[i].out, "carrier out");
            check(csdis, ROWS[i].cdis, "carrier disable");
        end
        // upper carrier on pin one held high, lower carrier grounded
        wr(DSM_CAR_OFS, 16'h0100);
        for (int k = 0; k < 16; k++) begin
            wr(DSM_SRC_OFS, 16'(k) | (k[0] ? 16'h0080 : 16'h0000));
            wr(DSM_CTRL_OFS, 16'h0001);
            lv <= 17'h2 | ((k > 0 && k < 15) ? 17'h1 << dbit(k) : 17'h0);
            settle();
            check(mod_out, k != 15, "data high");
            check(dsdis, k[0] ? 32'h1 << k : 32'h0, "data disable");
            wr(DSM_CTRL_OFS, 16'h0000);
            lv <= ~((k > 0 && k < 15) ? 17'h1 << dbit(k) : 17'h0);
            settle();
            check(mod_out, 1'b0, "data low");
        end
        wr(DSM_SRC_OFS, 16'h0000);
        sync_run(16'h2300, 1'b1, 1'b1);
        sync_run(16'h0023, 1'b0, 1'b1);
        sync_run(16'h0300, 1'b1, 1'b0);
        sync_run(16'h0003, 1'b0, 1'b0);
        // a running carrier must freeze while idle-stopped
        wr(DSM_CAR_OFS, 16'h0300);
        wr(DSM_CTRL_OFS, 16'h4001);
        ref_run <= 1'b1;
        idle <= 1'b1;
        settle();
        count_moves(moves);
        check(moves, 32'h0, "idle stop freeze");
        wr(DSM_CTRL_OFS, 16'h0001);
        count_moves(moves);
        check(moves > 0, 32'h1, "idle run");
        ce <= 1'b0;
        settle();
        count_moves(moves);
        check(moves, 32'h0, "clock enable low");
        ce <= 1'b1;
        idle <= 1'b0;
        ref_run <= 1'b0;
        // second reset: selector kept, disable bit and carrier cleared
        wr(DSM_SRC_OFS, 16'h0089);
        wr(DSM_CAR_OFS, 16'hA5A5);
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        check({30'h0, hready, mod_out}, 32'h2, "mid reset ready");
        check({dsdis, csdis}, 32'h0, "mid reset disables");
        srst <= 1'b0;
        bus(1'b0, DSM_SRC_OFS, 16'h0);
        check(q, 32'h0009, "source after reset");
        bus(1'b0, DSM_CAR_OFS, 16'h0);
        check(q, 32'h0000, "carrier after reset");
        bus(1'b0, DSM_STAT_OFS, 16'h0);
        check(q, 32'h0, "status after reset");
        complete_run();
    end
endmodule : signal_modulator_source_carrier_test
`default_nettype wire
